/* File: hdl/attach_pkg.sv */
// attach_pkg: constants, register map and types for the bus attach control block
// assumes: apb slave with 32-bit data, 200 MHz pclk
package attach_pkg;
   // =====================================================================
   // sizes
   localparam int pin_count = 16;
   localparam int pin_sel_w = 4;
   localparam int addr_w = 12;
   // synchroniser fill time after reset, in clocks
   localparam logic [1:0] settle_cycles = 2'h2;
   // =====================================================================
   // register byte offsets
   localparam logic [addr_w-1:0] ctrl_off = 12'h000;
   localparam logic [addr_w-1:0] pin_map_off = 12'h004;
   localparam logic [addr_w-1:0] power_off = 12'h008;
   localparam logic [addr_w-1:0] status_off = 12'h00c;
   localparam logic [addr_w-1:0] wake_off = 12'h010;
   // =====================================================================
   // ctrl fields
   localparam int ctrl_ready_bit = 0;
   localparam int ctrl_ext_pullup_bit = 1;
   localparam int ctrl_self_pwr_bit = 2;
   localparam int ctrl_audio_ep_bit = 3;
   localparam int ctrl_suspend_bit = 4;
   localparam int ctrl_inband_wake_bit = 5;
   localparam int ctrl_w = 6;
   localparam logic [ctrl_w-1:0] ctrl_reset = 6'h00;
   // =====================================================================
   // pin map fields: pull-up, power sense, detach, wake
   localparam int map_pullup_lsb = 0;
   localparam int map_sense_lsb = 4;
   localparam int map_detach_lsb = 8;
   localparam int map_wake_lsb = 12;
   localparam logic [15:0] pin_map_reset = 16'h3210;
   // =====================================================================
   // max power in mA, default 300 mA
   localparam int power_w = 10;
   localparam logic [power_w-1:0] max_power_reset = 10'h12c;
   // =====================================================================
   // status fields
   localparam int st_attached_bit = 0;
   localparam int st_detached_bit = 1;
   localparam int st_sense_bit = 2;
   localparam int st_pullup_bit = 3;
   localparam int st_suspend_bit = 4;
   localparam int st_wake_bit = 5;
   localparam int st_w = 6;
   // =====================================================================
   // attach state
   typedef enum logic [1:0] {
      st_off,
      st_waiting,
      st_detached
   } attach_state_t;
endpackage

/* File: hdl/attach_if.sv */
// attach_if: carries the bus-line controls between the control core and the pad stage
// assumes: both ends on pclk
`timescale 1ns/10ps
interface attach_if;
   logic line_enable;
   logic pullup_on;
   logic pullup_ext;
   logic [attach_pkg::pin_sel_w-1:0] pullup_pin;
   logic valid;
   logic ready;
   modport src (output line_enable, output pullup_on, output pullup_ext, output pullup_pin,
      output valid, input ready);
   modport dst (input line_enable, input pullup_on, input pullup_ext, input pullup_pin,
      input valid, output ready);
endinterface

/* File: hdl/attach_sync.sv */
// attach_sync: two-flop synchroniser for a bank of pins
// assumes: inputs asynchronous to pclk
`timescale 1ns/10ps
module attach_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins
   input wire logic [attach_pkg::pin_count-1:0] pin_raw,
   output logic [attach_pkg::pin_count-1:0] pin_sync
);
   import attach_pkg::*;
   typedef struct packed {
      logic [pin_count-1:0] meta;
      logic [pin_count-1:0] sync;
   } sync_state_t;
   sync_state_t s_q;
   sync_state_t s_d;
   always_comb begin
      s_d.meta = pin_raw;
      s_d.sync = s_q.meta;
   end
   // =====================================================================
   // two flops per pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign pin_sync = s_q.sync;
endmodule

/* File: hdl/attach_buf.sv */
// attach_buf: two-entry buffer for the line-control word
// assumes: source and sink on pclk
`timescale 1ns/10ps
module attach_buf (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // ports
   attach_if.dst in_p,
   attach_if.src out_p
);
   import attach_pkg::*;
   localparam int word_w = 3 + pin_sel_w;
   typedef struct packed {
      logic [1:0][word_w-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } buf_state_t;
   buf_state_t s_q;
   buf_state_t s_d;
   logic push;
   logic pop;
   always_comb begin
      s_d = s_q;
      push = in_p.valid && (s_q.count != 2'h2);
      pop = (s_q.count != 2'h0) && out_p.ready;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = {in_p.line_enable, in_p.pullup_on, in_p.pullup_ext,
            in_p.pullup_pin};
         s_d.wr_ptr = ~s_q.wr_ptr;
      end
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
      end
      s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
   end
   // =====================================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign in_p.ready = (s_q.count != 2'h2);
   assign out_p.valid = (s_q.count != 2'h0);
   assign {out_p.line_enable, out_p.pullup_on, out_p.pullup_ext, out_p.pullup_pin} =
      s_q.mem[s_q.rd_ptr];
endmodule

/* File: hdl/attach_ctrl.sv */
// attach_ctrl: bus attach and detach control with apb registers
// assumes: pins arrive asynchronously; pads tristate when line enable is low
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module attach_ctrl (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [attach_pkg::addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // general purpose pins
   input wire logic [attach_pkg::pin_count-1:0] gp_pin_in,
   output logic [attach_pkg::pin_count-1:0] gp_pin_out,
   output logic [attach_pkg::pin_count-1:0] gp_pin_oe_n,
   // bus line pad controls
   output logic bus_data_plus_oe_n,
   output logic bus_data_minus_oe_n,
   output logic internal_pullup_on,
   // to protocol engine and power
   output logic engine_enable,
   output logic engine_audio_ep,
   output logic [attach_pkg::power_w-1:0] max_power_value,
   output logic inband_wake_req,
   output logic radio_enable,
   output logic periph_power_on
);
   import attach_pkg::*;

   typedef struct packed {
      logic [ctrl_w-1:0] ctrl;
      logic [15:0] pin_map;
      logic [power_w-1:0] max_power;
      logic wake_req;
      attach_state_t state;
      logic [1:0] settle;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic dp_oe_n;
      logic dn_oe_n;
      logic int_pu;
      logic [pin_count-1:0] pin_out;
      logic [pin_count-1:0] pin_oe_n;
      logic eng_en;
      logic inband;
      logic radio;
      logic periph;
   } ctrl_state_t;

   ctrl_state_t s_q;
   ctrl_state_t s_d;
   logic [pin_count-1:0] pin_s;
   logic detach_level;
   logic sense_level;
   logic pullup_want;
   logic acc;
   logic [pin_sel_w-1:0] pu_pin;
   logic [pin_sel_w-1:0] se_pin;
   logic [pin_sel_w-1:0] de_pin;
   logic [pin_sel_w-1:0] wk_pin;
   logic [pin_count-1:0] drv_out;
   logic [pin_count-1:0] drv_oe_n;
   logic [st_w-1:0] status_word;

   attach_if buf_in ();
   attach_if buf_out ();

   // =====================================================================
   // pin synchroniser
   attach_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_raw(gp_pin_in),
      .pin_sync(pin_s)
   );

   // =====================================================================
   // line control buffer
   attach_buf u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .in_p(buf_in),
      .out_p(buf_out)
   );

   assign pu_pin = s_q.pin_map[map_pullup_lsb +: pin_sel_w];
   assign se_pin = s_q.pin_map[map_sense_lsb +: pin_sel_w];
   assign de_pin = s_q.pin_map[map_detach_lsb +: pin_sel_w];
   assign wk_pin = s_q.pin_map[map_wake_lsb +: pin_sel_w];
   assign detach_level = pin_s[de_pin];
   assign sense_level = pin_s[se_pin];
   // self-powered needs sense; bus-powered is powered only when present
   assign pullup_want = (s_q.state == st_waiting) && s_q.ctrl[ctrl_ready_bit]
      && (!s_q.ctrl[ctrl_self_pwr_bit] || sense_level);

   assign buf_in.valid = 1'b1;
   assign buf_in.line_enable = (s_q.state == st_waiting);
   assign buf_in.pullup_on = pullup_want;
   assign buf_in.pullup_ext = s_q.ctrl[ctrl_ext_pullup_bit];
   assign buf_in.pullup_pin = pu_pin;
   assign buf_out.ready = 1'b1;
   assign acc = psel && penable;

   // =====================================================================
   // per-pin drive: external pull-up pin and wake pin
   for (genvar g = 0; g < pin_count; g++) begin : g_pin
      logic pu_hit;
      logic wk_hit;
      assign pu_hit = buf_out.valid && buf_out.pullup_ext && buf_out.pullup_on
         && (buf_out.pullup_pin == pin_sel_w'(g));
      assign wk_hit = (wk_pin == pin_sel_w'(g));
      assign drv_oe_n[g] = !(wk_hit || pu_hit);
      assign drv_out[g] = wk_hit ? s_q.wake_req : pu_hit;
   end

   // =====================================================================
   // status word
   always_comb begin
      status_word = '0;
      status_word[st_attached_bit] = (s_q.state == st_waiting);
      status_word[st_detached_bit] = (s_q.state == st_detached);
      status_word[st_sense_bit] = sense_level;
      status_word[st_pullup_bit] = pullup_want;
      status_word[st_suspend_bit] = s_q.ctrl[ctrl_suspend_bit];
      status_word[st_wake_bit] = s_q.wake_req;
   end

   always_comb begin
      s_d = s_q;
      // ==================================================================
      // attach state
      case (s_q.state)
         st_off: begin
            // hold off until the pin synchroniser has filled
            if (s_q.settle != settle_cycles) begin
               s_d.settle = s_q.settle + 2'h1;
            end else if (detach_level) begin
               s_d.state = st_detached;
            end else begin
               s_d.state = st_waiting;
            end
         end
         st_waiting: begin
            if (detach_level) begin
               s_d.state = st_detached;
            end
         end
         st_detached: begin
            if (!detach_level) begin
               s_d.state = st_waiting;
               s_d.wake_req = 1'b0;
            end
         end
         default: begin
            s_d.state = st_off;
         end
      endcase
      // ==================================================================
      // apb access, one wait-free access phase
      s_d.ready = 1'b0;
      s_d.err = 1'b0;
      if (psel && !penable) begin
         s_d.ready = 1'b1;
      end
      if (acc && s_q.ready) begin
         s_d.ready = 1'b0;
      end
      if (psel && !penable) begin
         s_d.rdata = 32'h0000_0000;
         case (paddr)
            ctrl_off: s_d.rdata[ctrl_w-1:0] = s_q.ctrl;
            pin_map_off: s_d.rdata[15:0] = s_q.pin_map;
            power_off: s_d.rdata[power_w-1:0] = s_q.max_power;
            status_off: s_d.rdata[st_w-1:0] = status_word;
            wake_off: s_d.rdata[0] = s_q.wake_req;
            default: s_d.err = 1'b1;
         endcase
      end else if (acc && s_q.ready) begin
         s_d.err = 1'b0;
      end else begin
         s_d.err = s_q.err && !(acc && s_q.ready);
      end
      if (acc && s_q.ready && pwrite) begin
         case (paddr)
            ctrl_off: s_d.ctrl = pwdata[ctrl_w-1:0];
            pin_map_off: s_d.pin_map = pwdata[15:0];
            power_off: s_d.max_power = pwdata[power_w-1:0];
            wake_off: s_d.wake_req = pwdata[0] && (s_q.state == st_detached);
            default: s_d.rdata = s_q.rdata;
         endcase
      end
      if (s_q.state != st_detached) begin
         s_d.wake_req = 1'b0;
      end
      // ==================================================================
      // pad outputs from the buffered line word; engine and power outputs from the state and ctrl
      if (buf_out.valid) begin
         s_d.dp_oe_n = !buf_out.line_enable;
         s_d.dn_oe_n = !buf_out.line_enable;
         s_d.int_pu = buf_out.pullup_on && !buf_out.pullup_ext;
      end
      s_d.pin_oe_n = drv_oe_n;
      s_d.pin_out = drv_out;
      s_d.eng_en = (s_q.state == st_waiting);
      // in-band wake only while the buffered line word has the lines driven
      s_d.inband = s_q.ctrl[ctrl_inband_wake_bit] && s_q.ctrl[ctrl_suspend_bit]
         && buf_out.valid && buf_out.line_enable;
      s_d.radio = !(s_q.ctrl[ctrl_suspend_bit] && !s_q.ctrl[ctrl_self_pwr_bit]);
      s_d.periph = !s_q.ctrl[ctrl_suspend_bit];
   end

   // =====================================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ctrl <= ctrl_reset;
         s_q.pin_map <= pin_map_reset;
         s_q.max_power <= max_power_reset;
         s_q.state <= st_off;
         s_q.dp_oe_n <= 1'b1;
         s_q.dn_oe_n <= 1'b1;
         s_q.pin_oe_n <= '1;
         s_q.radio <= 1'b1;
         s_q.periph <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // =====================================================================
   // apb outputs
   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   // =====================================================================
   // pin and pad outputs
   assign gp_pin_out = s_q.pin_out;
   assign gp_pin_oe_n = s_q.pin_oe_n;
   assign bus_data_plus_oe_n = s_q.dp_oe_n;
   assign bus_data_minus_oe_n = s_q.dn_oe_n;
   assign internal_pullup_on = s_q.int_pu;
   // =====================================================================
   // engine and power outputs
   assign engine_enable = s_q.eng_en;
   assign engine_audio_ep = s_q.ctrl[ctrl_audio_ep_bit];
   assign max_power_value = s_q.max_power;
   assign inband_wake_req = s_q.inband;
   assign radio_enable = s_q.radio;
   assign periph_power_on = s_q.periph;
endmodule

/* File: verification/attach_ctrl_properties.sv */
// attach_ctrl_properties: port-level checks for attach_ctrl
// assumes: one pclk domain, bound to every attach_ctrl
`timescale 1ns/10ps
module attach_ctrl_properties (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [attach_pkg::addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and controls
   input wire logic [attach_pkg::pin_count-1:0] gp_pin_in,
   input wire logic [attach_pkg::pin_count-1:0] gp_pin_out,
   input wire logic [attach_pkg::pin_count-1:0] gp_pin_oe_n,
   input wire logic bus_data_plus_oe_n,
   input wire logic bus_data_minus_oe_n,
   input wire logic internal_pullup_on,
   input wire logic engine_audio_ep,
   input wire logic [attach_pkg::power_w-1:0] max_power_value,
   input wire logic inband_wake_req,
   input wire logic radio_enable,
   input wire logic periph_power_on
);
   import attach_pkg::*;
   // ===================================================
   // shadow of written settings
   logic [ctrl_w-1:0] ctrl_q;
   logic [15:0] map_q;
   logic [power_w-1:0] pwr_q;
   logic detach, sense, wake, ext;
   assign detach = gp_pin_in[map_q[11:8]];
   assign sense = gp_pin_in[map_q[7:4]];
   assign wake = gp_pin_out[map_q[15:12]] && !gp_pin_oe_n[map_q[15:12]];
   assign ext = gp_pin_out[map_q[3:0]] && !gp_pin_oe_n[map_q[3:0]];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= ctrl_reset;
         map_q <= pin_map_reset;
         pwr_q <= max_power_reset;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == ctrl_off) ctrl_q <= pwdata[ctrl_w-1:0];
         if (paddr == pin_map_off) map_q <= pwdata[15:0];
         if (paddr == power_off) pwr_q <= pwdata[power_w-1:0];
      end
   end
   // ===================================================
   // assertions
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_lines_paired: assert property (bus_data_plus_oe_n == bus_data_minus_oe_n)
      else $error("data lines not tristated together");
   chk_detach_off: assert property (detach [*8] |-> bus_data_plus_oe_n && !internal_pullup_on && !ext)
      else $error("detach held but lines or pull-up active");
   chk_detach_sync: assert property ($rose(detach) |=> !$rose(bus_data_plus_oe_n))
      else $error("detach acted without synchronising");
   chk_reattach_pullup: assert property ((ctrl_q[0] && ctrl_q[4:1] == 4'h0 && !detach) [*8]
      |-> internal_pullup_on && !bus_data_plus_oe_n)
      else $error("ready and attached but no pull-up");
   chk_ready_gate: assert property ((!ctrl_q[0]) [*8] |-> !internal_pullup_on && !ext)
      else $error("pull-up on while not ready");
   chk_self_sense: assert property ((ctrl_q[2] && !sense) [*8] |-> !internal_pullup_on && !ext)
      else $error("pull-up on without bus power");
   chk_ext_source: assert property (ctrl_q[1] [*8] |-> !internal_pullup_on)
      else $error("internal pull-up on in external mode");
   chk_wake_detached: assert property (wake |-> bus_data_plus_oe_n || $past(bus_data_plus_oe_n))
      else $error("wake driven while attached");
   chk_no_inband: assert property (bus_data_plus_oe_n |-> !inband_wake_req)
      else $error("in-band wake while detached");
   chk_suspend_radio: assert property ((ctrl_q[4] && !ctrl_q[2]) [*8]
      |-> !radio_enable && !periph_power_on)
      else $error("radio or periphery on in bus-powered suspend");
   chk_audio_set: assert property ($stable(ctrl_q[3]) [*4] |-> engine_audio_ep == ctrl_q[3])
      else $error("endpoint set differs from setting");
   chk_power_value: assert property ($stable(pwr_q) [*4] |-> max_power_value == pwr_q)
      else $error("max power differs from setting");
   chk_refused_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   cover property (detach [*8]);
   cover property (wake);
   cover property (pready && pslverr);
   cover property (ctrl_q[4] && !radio_enable);
endmodule
bind attach_ctrl attach_ctrl_properties chk_i (.*);

/* File: verification/host_side.sv */
// host_side: bus power sense and detach drive from the host side
// assumes: bench sets power_on and detach_on after pclk edges
`timescale 1ns/10ps
module host_side #(
   parameter int sense_pin = 5,
   parameter int detach_pin = 6
) (
   // clock
   input wire logic pclk,
   // from bench
   input wire logic power_on,
   input wire logic detach_on,
   // device side
   input wire logic pullup_seen,
   output logic [attach_pkg::pin_count-1:0] gp_pin_in,
   output int enum_count
);
   import attach_pkg::*;
   logic seen_q = 1'b0;
   int count_q = 0;
   assign enum_count = count_q;
   // each new pull-up is a fresh enumeration by the host
   always @(posedge pclk) begin
      seen_q <= pullup_seen;
      if (pullup_seen && !seen_q) count_q <= count_q + 1;
   end
   // unused pins pulled low
   always_comb begin
      gp_pin_in = '0;
      gp_pin_in[sense_pin] = power_on;
      gp_pin_in[detach_pin] = detach_on;
   end
endmodule

/* File: verification/testbench.sv */
// testbench: apb register and pin scenarios for attach_ctrl
// assumes: attach_pkg compiled first, host_side as far side
`timescale 1ns/10ps
module testbench;
   import attach_pkg::*;
   typedef struct packed {
      logic w;
      logic [addr_w-1:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic err;
   } row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [addr_w-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [pin_count-1:0] gp_pin_in, gp_pin_out, gp_pin_oe_n;
   logic bus_data_plus_oe_n, bus_data_minus_oe_n, internal_pullup_on, engine_enable;
   logic engine_audio_ep, inband_wake_req, radio_enable, periph_power_on;
   logic power_on, detach_on, pullup_seen;
   logic [power_w-1:0] max_power_value;
   int n_errors = 0;
   int check_count = 0;
   int n, m, enums;
   row_t rows [13] = '{
      '{1'b0, ctrl_off, 32'h0, 32'h0, 1'b0},
      '{1'b0, pin_map_off, 32'h0, 32'h3210, 1'b0},
      '{1'b0, power_off, 32'h0, 32'h12c, 1'b0},
      '{1'b1, power_off, 32'h1f4, 32'h0, 1'b0},
      '{1'b0, power_off, 32'h0, 32'h1f4, 1'b0},
      '{1'b1, pin_map_off, 32'h7654, 32'h0, 1'b0},
      '{1'b0, pin_map_off, 32'h0, 32'h7654, 1'b0},
      '{1'b1, 12'h020, 32'h1, 32'h0, 1'b1},
      '{1'b0, 12'h020, 32'h0, 32'h0, 1'b1},
      '{1'b0, status_off, 32'h0, 32'h1, 1'b0},
      '{1'b1, status_off, 32'h3f, 32'h0, 1'b0},
      '{1'b0, status_off, 32'h0, 32'h1, 1'b0},
      '{1'b0, wake_off, 32'h0, 32'h0, 1'b0}};
   attach_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
      .gp_pin_oe_n(gp_pin_oe_n), .bus_data_plus_oe_n(bus_data_plus_oe_n),
      .bus_data_minus_oe_n(bus_data_minus_oe_n), .internal_pullup_on(internal_pullup_on),
      .engine_enable(engine_enable), .engine_audio_ep(engine_audio_ep),
      .max_power_value(max_power_value), .inband_wake_req(inband_wake_req),
      .radio_enable(radio_enable), .periph_power_on(periph_power_on));
   host_side model (.pclk(pclk), .power_on(power_on), .detach_on(detach_on),
      .pullup_seen(pullup_seen), .gp_pin_in(gp_pin_in), .enum_count(enums));
   assign pullup_seen = internal_pullup_on | (gp_pin_out[4] & ~gp_pin_oe_n[4]);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ===================================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [addr_w-1:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_errors++;
         end_of_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (8) @(posedge pclk);
   endtask
   task automatic wait_line(input logic e);
      n = 0;
      while (bus_data_plus_oe_n !== e && n < 30) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 30) begin
         n_errors++;
         end_of_test;
      end
   endtask
   // ===================================================
   // sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      power_on = 1'b0;
      detach_on = 1'b0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      chk({bus_data_plus_oe_n, internal_pullup_on}, 2'b10);
      presetn <= 1'b1;
      foreach (rows[k]) begin
         apb(rows[k].w, rows[k].a, rows[k].d);
         if (!rows[k].w) chk(rd, rows[k].e);
         chk(er, rows[k].err);
      end
      chk(max_power_value, 10'h1f4);
      apb(1'b1, ctrl_off, 32'h1);
      settle;
      chk({internal_pullup_on, bus_data_plus_oe_n, engine_enable}, 3'b101);
      apb(1'b1, ctrl_off, 32'h9);
      settle;
      chk(engine_audio_ep, 1'b1);
      apb(1'b1, ctrl_off, 32'h3);
      settle;
      chk({internal_pullup_on, gp_pin_out[4], gp_pin_oe_n[4]}, 3'b010);
      apb(1'b1, ctrl_off, 32'h5);
      apb(1'b1, wake_off, 32'h1);
      settle;
      chk({pullup_seen, gp_pin_out[7] & ~gp_pin_oe_n[7]}, 2'b00);
      power_on <= 1'b1;
      settle;
      chk(internal_pullup_on, 1'b1);
      detach_on <= 1'b1;
      wait_line(1'b1);
      chk(n >= 3, 1'b1);
      chk({bus_data_minus_oe_n, internal_pullup_on, engine_enable}, 3'b100);
      apb(1'b1, ctrl_off, 32'h35);
      apb(1'b1, wake_off, 32'h1);
      settle;
      chk(inband_wake_req, 1'b0);
      chk({gp_pin_out[7], gp_pin_oe_n[7]}, 2'b10);
      m = enums;
      detach_on <= 1'b0;
      wait_line(1'b0);
      settle;
      chk({gp_pin_out[7] & ~gp_pin_oe_n[7], internal_pullup_on}, 2'b01);
      chk(enums, m + 1);
      chk(inband_wake_req, 1'b1);
      apb(1'b1, ctrl_off, 32'h11);
      settle;
      chk({radio_enable, periph_power_on}, 2'b00);
      apb(1'b1, ctrl_off, 32'h15);
      settle;
      chk(radio_enable, 1'b1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({bus_data_plus_oe_n, radio_enable, max_power_value}, {2'b11, 10'h12c});
      presetn <= 1'b1;
      apb(1'b0, pin_map_off, 32'h0);
      chk(rd, 32'h3210);
      end_of_test;
   end
endmodule
